// *** dpoc_output_ctrl.v ***
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "dpoc_regs.vh"
module dpoc_output_ctrl #(
   parameter DATA_W = 24,
   parameter CTRL_W = 3
) (
   input  wire                    CLK_SYS,
   input  wire                    RESET_N,
   input  wire                    POWER_DOWN_BAR,
   input  wire                    LINK_LOCKED,
   input  wire                    STRAP_OUTPUTS_LOW_HOLD,
   input  wire                    STRAP_SLEEP_OUTPUT_STATE_SELECT,
   input  wire                    STRAP_STROBE_EDGE_SELECT,
   input  wire                    STRAP_DATA_OUTPUT_SLEW_BOOST,
   input  wire [DATA_W-1:0]       RX_DATA,
   input  wire [CTRL_W-1:0]       RX_CTRL,
   input  wire [`DPOC_ADDR_W-1:0] REG_ADDR,
   input  wire [7:0]              REG_WDATA,
   input  wire                    REG_WR,
   input  wire                    REG_RD,
   output reg  [7:0]              REG_RDATA,
   output reg  [DATA_W-1:0]       PAR_DATA,
   output reg  [CTRL_W-1:0]       PAR_CTRL,
   output reg                     PAR_DATA_OE,
   output reg                     PAR_CLK,
   output reg                     STROBE_EDGE_SELECT,
   output reg                     DATA_OUTPUT_SLEW_BOOST,
   output wire                    OUTPUTS_ACTIVE
);
   // Synchroniser lane order
   localparam lane_slew  = 0;
   localparam lane_edge  = 1;
   localparam lane_sleep = 2;
   localparam lane_hold  = 3;
   localparam lane_lock  = 4;
   localparam lane_pdb   = 5;
   localparam lane_n     = 6;

   wire [lane_n-1:0] pins_raw;
   wire [lane_n-1:0] pins_s;
   wire [7:0]        ctrl_word;
   wire [7:0]        status_word;
   reg        pd_prev_reg;
   reg        hold_reg;
   reg        sleep_sel_reg;
   reg        edge_reg;
   reg        slew_reg;
   reg        ovr_reg;
   reg        hold_rel_reg;
   reg        edge_phase_reg;
   wire       pdb_s;
   wire       lock_s;
   wire       wake;
   wire       eff_hold;
   wire       eff_sleep;
   wire       eff_edge;
   wire       eff_slew;
   wire       run;
   wire       hold_src;
   wire       sleep_src;
   wire       ctrl_wr_hit;
   wire       launch;

   // Pin lanes into synchroniser
   assign pins_raw[lane_pdb]   = POWER_DOWN_BAR;
   assign pins_raw[lane_lock]  = LINK_LOCKED;
   assign pins_raw[lane_hold]  = STRAP_OUTPUTS_LOW_HOLD;
   assign pins_raw[lane_sleep] = STRAP_SLEEP_OUTPUT_STATE_SELECT;
   assign pins_raw[lane_edge]  = STRAP_STROBE_EDGE_SELECT;
   assign pins_raw[lane_slew]  = STRAP_DATA_OUTPUT_SLEW_BOOST;

   dpoc_sync2 #(.W(lane_n)) u_sync (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .d     (pins_raw),
      .q     (pins_s)
   );
   assign pdb_s  = pins_s[lane_pdb];
   assign lock_s = pins_s[lane_lock];
   assign wake   = pdb_s & ~pd_prev_reg;

   assign eff_hold  = hold_reg;
   assign hold_src  = pdb_s ? hold_reg : pins_s[lane_hold];
   assign sleep_src = pdb_s ? sleep_sel_reg : pins_s[lane_sleep];
   assign eff_sleep = ovr_reg ? sleep_sel_reg : (hold_src ? 1'b0 : sleep_src);
   assign eff_edge  = edge_reg;
   assign eff_slew  = slew_reg;

   assign run = pdb_s & lock_s & (~eff_hold | hold_rel_reg);
   assign OUTPUTS_ACTIVE = run;

   assign launch = run & (edge_phase_reg != eff_edge);

   // Register write decode
   assign ctrl_wr_hit = REG_WR & (REG_ADDR == `DPOC_ADDR_CTRL);

   // Register read words
   assign ctrl_word[`DPOC_BIT_HOLD_REL]            = hold_rel_reg;
   assign ctrl_word[`DPOC_BIT_SLEEP_SEL]           = sleep_sel_reg;
   assign ctrl_word[`DPOC_BIT_EDGE_SEL]            = edge_reg;
   assign ctrl_word[`DPOC_BIT_SLEW]                = slew_reg;
   assign ctrl_word[`DPOC_BIT_OVR_EN]              = ovr_reg;
   assign ctrl_word[`DPOC_PAD_MSB:`DPOC_PAD_LSB]   = 3'h0;
   assign status_word[`DPOC_STAT_SLEEP]            = eff_sleep;
   assign status_word[`DPOC_STAT_PDB]              = pdb_s;
   assign status_word[`DPOC_STAT_LOCK]             = lock_s;
   assign status_word[`DPOC_STAT_RUN]              = run;
   assign status_word[`DPOC_STAT_HOLD]             = eff_hold;
   assign status_word[`DPOC_PAD_MSB:`DPOC_PAD_LSB] = 3'h0;

   always @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         pd_prev_reg   <= 1'b0;
         hold_reg      <= 1'b0;
         sleep_sel_reg <= 1'b0;
         edge_reg      <= 1'b0;
         slew_reg      <= 1'b0;
         ovr_reg       <= 1'b0;
         hold_rel_reg  <= 1'b0;
      end else begin
         pd_prev_reg <= pdb_s;
         if (!pdb_s) begin
            hold_reg      <= 1'b0;
            sleep_sel_reg <= 1'b0;
            edge_reg      <= 1'b0;
            slew_reg      <= 1'b0;
            ovr_reg       <= 1'b0;
            hold_rel_reg  <= 1'b0;
         end else if (wake) begin
            hold_reg      <= pins_s[lane_hold];
            sleep_sel_reg <= pins_s[lane_sleep];
            edge_reg      <= pins_s[lane_edge];
            slew_reg      <= pins_s[lane_slew];
         end else if (ctrl_wr_hit) begin
            hold_rel_reg  <= REG_WDATA[`DPOC_BIT_HOLD_REL];
            sleep_sel_reg <= REG_WDATA[`DPOC_BIT_SLEEP_SEL];
            edge_reg      <= REG_WDATA[`DPOC_BIT_EDGE_SEL];
            slew_reg      <= REG_WDATA[`DPOC_BIT_SLEW];
            ovr_reg       <= REG_WDATA[`DPOC_BIT_OVR_EN];
         end
      end
   end

   always @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         REG_RDATA <= `DPOC_CTRL_RESET;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `DPOC_ADDR_CTRL: begin
               REG_RDATA <= ctrl_word;
            end
            `DPOC_ADDR_STATUS: begin
               REG_RDATA <= status_word;
            end
            default: begin
               REG_RDATA <= 8'h00;
            end
         endcase
      end else begin
         // Read data stands one cycle only
         REG_RDATA <= 8'h00;
      end
   end

   always @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         STROBE_EDGE_SELECT     <= 1'b0;
         DATA_OUTPUT_SLEW_BOOST <= 1'b0;
      end else begin
         STROBE_EDGE_SELECT     <= eff_edge;
         DATA_OUTPUT_SLEW_BOOST <= eff_slew;
      end
   end

   // Output clock phase
   always @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         edge_phase_reg <= 1'b0;
         PAR_CLK        <= 1'b0;
      end else begin
         edge_phase_reg <= ~edge_phase_reg;
         PAR_CLK        <= run ? edge_phase_reg : 1'b0;
      end
   end

   always @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         PAR_DATA               <= {DATA_W{1'b0}};
         PAR_CTRL               <= {CTRL_W{1'b0}};
         PAR_DATA_OE            <= 1'b0;
      end else begin
         if (!pdb_s) begin
            PAR_DATA    <= {DATA_W{1'b0}};
            PAR_CTRL    <= {CTRL_W{1'b0}};
            PAR_DATA_OE <= ~eff_sleep;
         end else if (!run) begin
            PAR_DATA    <= {DATA_W{1'b0}};
            PAR_CTRL    <= {CTRL_W{1'b0}};
            PAR_DATA_OE <= 1'b1;
         end else if (launch) begin
            PAR_DATA    <= RX_DATA;
            PAR_CTRL    <= RX_CTRL;
            PAR_DATA_OE <= 1'b1;
         end
      end
   end
endmodule // dpoc_output_ctrl

// *** dpoc_output_ctrl_chk.sv ***
`timescale 1ns/1ps
module dpoc_chk #(parameter DATA_W = 24, parameter CTRL_W = 3) (
   input wire logic              CLK_SYS,
   input wire logic              RESET_N,
   input wire logic              POWER_DOWN_BAR,
   input wire logic              LINK_LOCKED,
   input wire logic              REG_WR,
   input wire logic [DATA_W-1:0] PAR_DATA,
   input wire logic [CTRL_W-1:0] PAR_CTRL,
   input wire logic              PAR_CLK,
   input wire logic              STROBE_EDGE_SELECT,
   input wire logic              DATA_OUTPUT_SLEW_BOOST,
   input wire logic              OUTPUTS_ACTIVE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   idle_low_a: assert property (!OUTPUTS_ACTIVE |=> PAR_DATA == '0 && PAR_CTRL == '0) else $error("not low");
   clk_quiet_a: assert property (!OUTPUTS_ACTIVE |=> !PAR_CLK) else $error("clock runs");
   clk_run_a: assert property (OUTPUTS_ACTIVE [*2] |=> PAR_CLK != $past(PAR_CLK)) else $error("clock stuck");
   lock_gate_a: assert property (!LINK_LOCKED [*3] |-> !OUTPUTS_ACTIVE) else $error("active unlocked");
   sleep_low_a: assert property (!POWER_DOWN_BAR [*4] |-> PAR_DATA == '0 && !PAR_CLK) else $error("sleep");
   pd_off_a: assert property (!POWER_DOWN_BAR [*3] |-> !OUTPUTS_ACTIVE) else $error("active in sleep");
   edge_sel_a: assert property ($changed(PAR_DATA) && PAR_DATA != '0 && $stable(STROBE_EDGE_SELECT)
      && OUTPUTS_ACTIVE |=> PAR_CLK == $past(STROBE_EDGE_SELECT)) else $error("wrong edge");
   strap_hold_a: assert property ($past(RESET_N, 8) && $past(POWER_DOWN_BAR, 6) && POWER_DOWN_BAR
      && !$past(REG_WR) && !$past(REG_WR, 2) |=> $stable(STROBE_EDGE_SELECT) && $stable(DATA_OUTPUT_SLEW_BOOST))
      else $error("strap not latched");
   cover property (OUTPUTS_ACTIVE && STROBE_EDGE_SELECT);
   cover property (OUTPUTS_ACTIVE && !STROBE_EDGE_SELECT);
   cover property ($fell(POWER_DOWN_BAR));
endmodule // dpoc_chk
bind dpoc_output_ctrl dpoc_chk #(.DATA_W(DATA_W), .CTRL_W(CTRL_W)) i_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .POWER_DOWN_BAR(POWER_DOWN_BAR), .LINK_LOCKED(LINK_LOCKED), .REG_WR(REG_WR), .PAR_DATA(PAR_DATA),
   .PAR_CTRL(PAR_CTRL), .PAR_CLK(PAR_CLK), .STROBE_EDGE_SELECT(STROBE_EDGE_SELECT),
   .DATA_OUTPUT_SLEW_BOOST(DATA_OUTPUT_SLEW_BOOST), .OUTPUTS_ACTIVE(OUTPUTS_ACTIVE));

// *** dpoc_regs.vh ***
`ifndef DPOC_REGS_VH
`define DPOC_REGS_VH
`define DPOC_ADDR_W        4
`define DPOC_ADDR_CTRL     4'h0
`define DPOC_ADDR_STATUS   4'h1
`define DPOC_BIT_HOLD_REL  0
`define DPOC_BIT_SLEEP_SEL 1
`define DPOC_BIT_EDGE_SEL  2
`define DPOC_BIT_SLEW      3
`define DPOC_BIT_OVR_EN    4
`define DPOC_STAT_SLEEP    0
`define DPOC_STAT_PDB      1
`define DPOC_STAT_LOCK     2
`define DPOC_STAT_RUN      3
`define DPOC_STAT_HOLD     4
`define DPOC_PAD_MSB       7
`define DPOC_PAD_LSB       5
`define DPOC_CTRL_RESET    8'h00
`define DPOC_SYNC_RESET    2'h0
`endif

// *** dpoc_rx_model.sv ***
`timescale 1ns/1ps
module dpoc_rx_model (
   input  wire logic        par_clk,
   input  wire logic        edge_sel,
   input  wire logic [23:0] par_data,
   output int               n
);
   logic [23:0] cap;
   initial n = 0;
   always @(par_clk) if (par_clk === edge_sel) begin
      if (par_data !== cap) n <= n + 1;
      cap <= par_data;
   end
endmodule // dpoc_rx_model

// *** dpoc_sync2.v ***
`timescale 1ns/1ps
module dpoc_sync2 #(
   parameter W = 8
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   always @(posedge clk) begin
      if (!rst_n) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end
   assign q = s2_reg;
endmodule // dpoc_sync2

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic clk, rst_n, pwr, lock, s_hold, s_slp, s_edge, s_slew, wr, rd, rd_d, oe, pclk, edg, slew, act;
   logic [23:0] rxd, pd;
   logic [2:0]  rxc, pc;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [7:0]  exp_q[$];
   int          bad_count, n_tests, rx_n, n0, i;
   dpoc_output_ctrl i_dut (.CLK_SYS(clk), .RESET_N(rst_n), .POWER_DOWN_BAR(pwr), .LINK_LOCKED(lock),
      .STRAP_OUTPUTS_LOW_HOLD(s_hold), .STRAP_SLEEP_OUTPUT_STATE_SELECT(s_slp), .STRAP_STROBE_EDGE_SELECT(s_edge),
      .STRAP_DATA_OUTPUT_SLEW_BOOST(s_slew), .RX_DATA(rxd), .RX_CTRL(rxc), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PAR_DATA(pd), .PAR_CTRL(pc), .PAR_DATA_OE(oe), .PAR_CLK(pclk),
      .STROBE_EDGE_SELECT(edg), .DATA_OUTPUT_SLEW_BOOST(slew), .OUTPUTS_ACTIVE(act));
   dpoc_rx_model i_rx (.par_clk(pclk), .edge_sel(edg), .par_data(pd), .n(rx_n));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1; end
      @(posedge clk) wr <= 0;
   endtask
   task rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk) begin addr <= a; rd <= 1; exp_q.push_back(e); end
      @(posedge clk) rd <= 0;
   endtask
   always @(posedge clk) begin
      rxd <= 24'($urandom);
      rxc <= 3'($urandom);
      rd_d <= rd;
      if (rd_d) chk(rdata, exp_q.pop_front());
   end
   initial begin
      #200000 bad_count++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(37154));
      {rst_n, pwr, lock, s_hold, s_slp, s_edge, s_slew, wr, rd, addr, wdata} = 0;
      {pwr, lock, s_hold} = 3'h7;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      w(10);
      chk({7'h0, act}, 8'h00);
      chk({6'h0, edg, slew}, 8'h00);
      rd_reg(4'h1, 8'h16);
      rd_reg(4'($urandom_range(15, 2)), 8'h00);
      for (i = 0; i < 2; i++) begin
         wr_reg(4'h0, i ? 8'h05 : 8'h09);
         w(6);
         chk({7'h0, act}, 8'h01);
         chk({6'h0, edg, slew}, i ? 8'h02 : 8'h01);
         n0 = rx_n;
         w(12);
         chk({7'h0, rx_n > n0}, 8'h01);
      end
      rd_reg(4'h1, 8'h1E);
      {pwr, s_hold, s_edge, s_slew, s_slp} <= 5'h06;
      w(8);
      chk({7'h0, oe}, 8'h01);
      wr_reg(4'h0, 8'h05);
      pwr <= 1;
      s_slp <= 1;
      w(8);
      chk({7'h0, act}, 8'h01);
      chk({6'h0, edg, slew}, 8'h03);
      rd_reg(4'h0, 8'h0E);
      @(posedge clk) lock <= 0;
      w(5);
      chk({7'h0, act}, 8'h00);
      rd_reg(4'h1, 8'h03);
      pwr <= 0;
      w(8);
      chk({7'h0, oe}, 8'h00);
      tally_and_finish;
   end
endmodule // testbench
